// ==== rtl/cps_status_regs.sv ====
// Module: accepted-profile and pin/power status registers of the charging port controller
module cps_status_regs
    import cps_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Control pins and software overrides
    input wire logic port_power_enable,
    input wire logic port_power_enable_sw,
    input wire logic port_power_enable_ovr,
    input wire logic mode_select_a,
    input wire logic mode_select_a_sw,
    input wire logic mode_select_a_ovr,
    input wire logic mode_select_b,
    input wire logic mode_select_b_sw,
    input wire logic mode_select_b_ovr,
    input wire logic emulation_enable,
    input wire logic emulation_enable_sw,
    input wire logic emulation_enable_ovr,
    input wire logic polarity_select,
    // Power state and emulation events
    input wire logic [1:0] power_state,
    input wire logic [6:0] profile_accept,
    input wire logic removal_event,
    input wire logic emul_cycle_data_switch_ctl,
    input wire logic default_data_switch,
    // Register access port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // Register read data and status outputs
    output logic [7:0] reg_rdata_r,
    output logic reg_rvalid_r,
    output logic wake_req_r,
    output logic data_switch_r,
    output logic custom_limit_r,
    output logic [6:0] profile_flags_r,
    output logic [7:0] pin_status_r
);

    logic port_power_enable_eff;
    logic mode_a_eff;
    logic mode_b_eff;
    logic emul_eff;
    logic port_power_enable_on;
    logic port_power_enable_d_r;
    logic [1:0] mode_d_r;
    logic pwr_off_edge;
    logic mode_changed;
    logic clear_all;
    logic polarity_r;
    logic pol_captured_r;
    logic [1:0] power_state_field;
    logic [7:0] rdata_nxt;

    // ****************************************
    // Effective control levels
    // ****************************************
    // A set override bit replaces the pin level with the software value
    assign port_power_enable_eff = port_power_enable_ovr ? port_power_enable_sw : port_power_enable;
    assign mode_a_eff = mode_select_a_ovr ? mode_select_a_sw : mode_select_a;
    assign mode_b_eff = mode_select_b_ovr ? mode_select_b_sw : mode_select_b;
    assign emul_eff = emulation_enable_ovr ? emulation_enable_sw : emulation_enable;
    // Enable is on when its level matches the captured polarity
    assign port_power_enable_on = (port_power_enable_eff == polarity_r);

    // ****************************************
    // Polarity capture after reset release
    // ****************************************
    // The strap is read once; later strap changes wait for the next reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            polarity_r <= 1'b0;
            pol_captured_r <= 1'b0;
        end else if (clk_en && !pol_captured_r) begin
            polarity_r <= polarity_select;
            pol_captured_r <= 1'b1;
        end
    end

    // ****************************************
    // Clear conditions for profile flags
    // ****************************************
    // Previous-cycle images for edge and change detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_power_enable_d_r <= 1'b0;
            mode_d_r <= 2'h0;
        end else if (clk_en) begin
            port_power_enable_d_r <= port_power_enable_on;
            mode_d_r <= {mode_b_eff, mode_a_eff};
        end
    end

    // ****************************************
    // Profile clear request
    // ****************************************
    // Enable leaving its active level, judged against the captured polarity
    assign pwr_off_edge = port_power_enable_d_r && !port_power_enable_on;
    // Any change of the effective mode pair selects a new active mode
    assign mode_changed = (mode_d_r != {mode_b_eff, mode_a_eff});
    // Clear beats a same-cycle accept, so a stale handshake never survives
    assign clear_all = pwr_off_edge || mode_changed || removal_event;

    // ****************************************
    // Profile flag storage
    // ****************************************
    cps_profile_flags #(
        .NUM_PROFILES(CPS_NUM_PROFILES)
    ) u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .accept_pulse(profile_accept),
        .clear_all(clear_all),
        .flags_r(profile_flags_r)
    );

    // ****************************************
    // Switch steering while a profile is accepted
    // ****************************************
    // Flags feed the data switch and the custom limit here, never alert or attach detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_switch_r <= 1'b0;
            custom_limit_r <= 1'b0;
        end else if (clk_en) begin
            if (|profile_flags_r) begin
                data_switch_r <= emul_cycle_data_switch_ctl;
                custom_limit_r <= 1'b1;
            end else begin
                // No accepted profile: the switch falls back to its default control
                data_switch_r <= default_data_switch;
                custom_limit_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Wake request on port access
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_req_r <= 1'b0;
        end else if (clk_en) begin
            // Reads and writes both count as accesses
            wake_req_r <= reg_rd || reg_wr;
        end
    end

    // ****************************************
    // Power state as seen by a register read
    // ****************************************
    // The read is itself an access, so sleep shows as detect, the state it wakes into
    assign power_state_field = (power_state == CPS_PS_SLEEP) ? CPS_PS_DETECT : power_state;

    // ****************************************
    // Live pin status image
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_status_r <= CPS_RDATA_RST;
        end else if (clk_en) begin
            // Bit 7 is unimplemented and stays zero
            pin_status_r <= 8'h00;
            pin_status_r[CPS_PIN_PORT_POWER_ENABLE_BIT] <= port_power_enable_eff;
            pin_status_r[CPS_PIN_MODE_B_BIT] <= mode_b_eff;
            pin_status_r[CPS_PIN_MODE_A_BIT] <= mode_a_eff;
            pin_status_r[CPS_PIN_EMUL_BIT] <= emul_eff;
            pin_status_r[CPS_PIN_POL_BIT] <= polarity_r;
            // Raw state here; only the register read hides sleep
            pin_status_r[1:0] <= power_state;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Address decode of the two status registers; anything else reads zero
    always_comb begin
        rdata_nxt = CPS_RDATA_RST;
        // Bit 7 of both registers is unimplemented and reads zero
        case (reg_addr)
            CPS_ADDR_PROFILE: rdata_nxt = {1'b0, profile_flags_r};
            CPS_ADDR_PIN: rdata_nxt = {1'b0, port_power_enable_eff, mode_b_eff, mode_a_eff, emul_eff,
                                       polarity_r, power_state_field};
            default: rdata_nxt = CPS_RDATA_RST;
        endcase
    end

    // Writes are not decoded at all, reads change no state
    // Write data is accepted on the port and deliberately left unread
    // Read data holds until the next read; valid follows the read strobe one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= CPS_RDATA_RST;
            reg_rvalid_r <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end

endmodule // cps_status_regs

// ==== include/cps_pkg.sv ====
// Package: offsets, field positions and encodings of the charger port status registers
package cps_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CPS_ADDR_PROFILE = 8'h13;
    localparam logic [7:0] CPS_ADDR_PIN = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CPS_NUM_PROFILES = 7;
    localparam logic [6:0] CPS_PROFILE_RST = 7'h00;
    localparam int CPS_PIN_PORT_POWER_ENABLE_BIT = 6;
    localparam int CPS_PIN_MODE_B_BIT = 5;
    localparam int CPS_PIN_MODE_A_BIT = 4;
    localparam int CPS_PIN_EMUL_BIT = 3;
    localparam int CPS_PIN_POL_BIT = 2;
    localparam logic [7:0] CPS_RDATA_RST = 8'h00;

    // ****************************************
    // Power state encodings
    // ****************************************
    localparam logic [1:0] CPS_PS_SLEEP = 2'h0;
    localparam logic [1:0] CPS_PS_DETECT = 2'h1;
    localparam logic [1:0] CPS_PS_ACTIVE = 2'h2;
    localparam logic [1:0] CPS_PS_ERROR = 2'h3;

endpackage

// ==== rtl/cps_profile_flags.sv ====
// Module: accepted legacy profile flags with their clear conditions
module cps_profile_flags
    import cps_pkg::*;
#(
    parameter int NUM_PROFILES = CPS_NUM_PROFILES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Emulation results
    input wire logic [NUM_PROFILES-1:0] accept_pulse,
    input wire logic clear_all,
    // Flags
    output logic [NUM_PROFILES-1:0] flags_r
);

    // Refuse a profile count the register cannot hold
    if (NUM_PROFILES < 1 || NUM_PROFILES > CPS_NUM_PROFILES) begin : g_bad_count
        $error("NUM_PROFILES must be 1 to 7");
    end

    // ****************************************
    // One flag per profile
    // ****************************************
    for (genvar i = 0; i < NUM_PROFILES; i++) begin : g_flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flags_r[i] <= 1'b0;
            end else if (clk_en) begin
                if (clear_all) begin
                    flags_r[i] <= 1'b0;
                end else if (accept_pulse[i]) begin
                    flags_r[i] <= 1'b1;
                end
            end
        end
    end

endmodule // cps_profile_flags

// ==== test/cps_status_regs_monitor.sv ====
// Checker: port assertions of the status register block
module cps_status_regs_monitor
    import cps_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Inputs watched
    input wire logic mode_select_a,
    input wire logic mode_select_a_sw,
    input wire logic mode_select_a_ovr,
    input wire logic [1:0] power_state,
    input wire logic [6:0] profile_accept,
    input wire logic removal_event,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    // Outputs watched
    input wire logic [7:0] reg_rdata_r,
    input wire logic reg_rvalid_r,
    input wire logic wake_req_r,
    input wire logic custom_limit_r,
    input wire logic [6:0] profile_flags_r,
    input wire logic [7:0] pin_status_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic eff_a = mode_select_a_ovr ? mode_select_a_sw : mode_select_a;
    wire logic rd_ok = clk_en && reg_rd;
    a_read_answer: assert property (rd_ok |=> reg_rvalid_r)
        else $error("read not answered");
    a_profile_image: assert property (
        rd_ok && reg_addr == CPS_ADDR_PROFILE |=> reg_rdata_r == {1'b0, $past(profile_flags_r)})
        else $error("profile read wrong");
    a_state_awake: assert property (
        rd_ok && reg_addr == CPS_ADDR_PIN |=> reg_rdata_r[1:0] != CPS_PS_SLEEP)
        else $error("sleep state read");
    a_removal_clears: assert property (clk_en && removal_event |=> profile_flags_r == '0)
        else $error("flags kept after removal");
    a_flag_cause: assert property (
        (profile_flags_r & ~$past(profile_flags_r) & ~$past(profile_accept)) == '0)
        else $error("flag set without handshake");
    a_limit_follows: assert property (clk_en && |profile_flags_r |=> custom_limit_r)
        else $error("custom limit not on");
    a_mode_view: assert property (
        clk_en |=> pin_status_r[CPS_PIN_MODE_A_BIT] == $past(eff_a))
        else $error("mode view wrong");
    a_state_raw: assert property (clk_en |=> pin_status_r[1:0] == $past(power_state))
        else $error("power state view wrong");
    a_wake_access: assert property (clk_en && (reg_rd || reg_wr) |=> wake_req_r)
        else $error("no wake on access");
    a_write_quiet: assert property (
        clk_en && reg_wr && !reg_rd |=> $stable(reg_rdata_r) && !reg_rvalid_r)
        else $error("write changed read port");
    c_profile_read: cover property (rd_ok && reg_addr == CPS_ADDR_PROFILE);
    c_removal: cover property (removal_event && |profile_flags_r);
    c_write: cover property (clk_en && reg_wr);
endmodule // cps_status_regs_monitor

bind cps_status_regs cps_status_regs_monitor mon (.*);

// ==== test/cps_host_model.sv ====
// Partner: management-port host issuing register strobes
module cps_host_model (
    // Clock
    input wire logic clk,
    // Register strobes
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    // Returned data
    input wire logic [7:0] reg_rdata_r
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse of the last value
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_r;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask
endmodule // cps_host_model

// ==== test/charger_port_status_regs_tb_top.sv ====
// Testbench: register reads of the charger port status block
module charger_port_status_regs_tb_top import cps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, removal_event = 1'b0;
    logic port_power_enable = 1'b1, port_power_enable_sw = 1'b0, port_power_enable_ovr = 1'b0;
    logic mode_select_a = 1'b0, mode_select_a_sw = 1'b1, mode_select_a_ovr = 1'b0;
    logic mode_select_b = 1'b0, mode_select_b_sw = 1'b0, mode_select_b_ovr = 1'b0;
    logic emulation_enable = 1'b1, emulation_enable_sw = 1'b0, emulation_enable_ovr = 1'b0;
    logic polarity_select = 1'b1, emul_cycle_data_switch_ctl = 1'b1, default_data_switch = 1'b0;
    logic [1:0] power_state = 2'h0;
    logic [6:0] profile_accept = 7'h00;
    logic reg_rd, reg_wr, wake_req_r, data_switch_r, custom_limit_r, reg_rvalid_r;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, pin_status_r, d;
    logic [6:0] profile_flags_r;
    int failures = 0, samples_checked = 0;
    cps_status_regs dut (.*);
    cps_host_model host (.*);
    always #2 clk = ~clk;
    function automatic logic e(input logic p, input logic s, input logic o);
        return o ? s : p;
    endfunction
    function automatic logic [7:0] pin_exp();
        return {1'b0, e(port_power_enable, port_power_enable_sw, port_power_enable_ovr),
            e(mode_select_b, mode_select_b_sw, mode_select_b_ovr),
            e(mode_select_a, mode_select_a_sw, mode_select_a_ovr),
            e(emulation_enable, emulation_enable_sw, emulation_enable_ovr), polarity_select,
            (power_state == CPS_PS_SLEEP) ? CPS_PS_DETECT : power_state};
    endfunction
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        samples_checked++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] x);
        host.rd(a, d);
        chk(n, x, d);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        rdchk("profile_rst", CPS_ADDR_PROFILE, 8'h00);
        for (int s = 0; s < 4; s++) begin
            power_state = s[1:0];
            mode_select_a_ovr = s[0];
            emulation_enable_ovr = s[0];
            mode_select_b = s[1];
            port_power_enable_ovr = s[1];
            @(negedge clk);
            rdchk("pin", CPS_ADDR_PIN, pin_exp());
            chk("pin_image", (pin_exp() & 8'hfc) | {6'h00, power_state}, pin_status_r);
        end
        {mode_select_a_ovr, emulation_enable_ovr, mode_select_b, port_power_enable_ovr} = 4'h0;
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            profile_accept = 7'h01 << i;
            emul_cycle_data_switch_ctl = i[0];
            @(negedge clk);
            profile_accept = 7'h00;
            rdchk("flags", CPS_ADDR_PROFILE, {1'b0, 7'h01 << i});
            chk("limit", 8'h01, {7'h00, custom_limit_r});
            chk("switch", {7'h00, emul_cycle_data_switch_ctl}, {7'h00, data_switch_r});
            removal_event = (i % 3 == 0);
            mode_select_a = mode_select_a ^ (i % 3 == 1);
            port_power_enable_ovr = (i % 3 == 2);
            @(negedge clk);
            removal_event = 1'b0;
            port_power_enable_ovr = 1'b0;
            rdchk("cleared", CPS_ADDR_PROFILE, 8'h00);
            chk("limit_off", 8'h00, {7'h00, custom_limit_r});
            chk("switch_off", {7'h00, default_data_switch}, {7'h00, data_switch_r});
        end
        profile_accept = 7'h08;
        @(negedge clk);
        profile_accept = 7'h00;
        host.wr(CPS_ADDR_PROFILE, 8'hff);
        host.wr(CPS_ADDR_PIN, 8'hff);
        rdchk("wr_ignored", CPS_ADDR_PROFILE, 8'h08);
        rdchk("reread", CPS_ADDR_PROFILE, 8'h08);
        rdchk("unmapped", 8'h20, 8'h00);
        clk_en = 1'b0;
        profile_accept = 7'h40;
        repeat (2) @(negedge clk);
        profile_accept = 7'h00;
        clk_en = 1'b1;
        rdchk("frozen", CPS_ADDR_PROFILE, 8'h08);
        polarity_select = 1'b0;
        port_power_enable = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        rdchk("profile_rst2", CPS_ADDR_PROFILE, 8'h00);
        rdchk("pin_low_pol", CPS_ADDR_PIN, pin_exp());
        profile_accept = 7'h10;
        @(negedge clk);
        profile_accept = 7'h00;
        rdchk("flag_low_pol", CPS_ADDR_PROFILE, 8'h10);
        port_power_enable = 1'b1;
        @(negedge clk);
        rdchk("pwr_off_clear", CPS_ADDR_PROFILE, 8'h00);
        wrap_up();
    end
endmodule // charger_port_status_regs_tb_top
